//--- inc/position_capture_pkg.sv
// Package with register map, field layouts and timing constants of the position capture block
package position_capture_pkg;
    localparam int unsigned clk_hz = 40_000_000;
    localparam int unsigned tick_ms = 4;
    localparam int unsigned tick_cycles = (clk_hz / 1000) * tick_ms;
    localparam int unsigned fan_hold_s = 10;
    localparam int unsigned fan_hold_cycles = clk_hz * fan_hold_s;
    localparam logic [7:0] temp_fan_c = 8'h5a;
    localparam logic [7:0] temp_trip_c = 8'h64;
    localparam logic [7:0] fault_overtemp = 8'h4a;
    localparam logic [7:0] fault_none = 8'h00;

    // Byte addresses of the register words
    localparam logic [7:0] addr_live_rev = 8'h00;
    localparam logic [7:0] addr_live_pos = 8'h04;
    localparam logic [7:0] addr_marker_rev = 8'h08;
    localparam logic [7:0] addr_marker_pos = 8'h0c;
    localparam logic [7:0] addr_freeze_rev = 8'h10;
    localparam logic [7:0] addr_freeze_pos = 8'h14;
    localparam logic [7:0] addr_freeze_flag = 8'h18;
    localparam logic [7:0] addr_feedback_ready = 8'h1c;
    localparam logic [7:0] addr_hold = 8'h20;
    localparam logic [7:0] addr_fault = 8'h24;
    localparam logic [7:0] addr_irq_status = 8'h28;
    localparam logic [7:0] addr_irq_mask = 8'h2c;
    localparam logic [7:0] addr_drive_reset = 8'h30;

    // Interrupt status bits
    localparam int unsigned irq_marker_bit = 0;
    localparam int unsigned irq_freeze_bit = 1;
    localparam int unsigned irq_fault_bit = 2;
    localparam int unsigned irq_width = 3;

    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;

    typedef struct packed {
        logic [15:0] rev;
        logic [15:0] pos;
    } position_s;
endpackage : position_capture_pkg

//--- sim/feedback_partner.sv
// Model of the encoder feed and of the option module that sources freeze events
`timescale 1ns/10ps
`default_nettype none
module feedback_partner (
    input wire logic aclk,
    output logic [15:0] encoder_rev,
    output logic [15:0] encoder_pos,
    output logic encoder_valid,
    output logic marker_in,
    output logic freeze_in
);
    // Feedback starts invalid and event lines idle low
    initial
    begin
        encoder_rev = 16'h0000;
        encoder_pos = 16'h0000;
        encoder_valid = 1'b0;
        marker_in = 1'b0;
        freeze_in = 1'b0;
    end
    // Every change lands just after a clock edge
    task automatic move(input logic [15:0] r, input logic [15:0] p);
        @(posedge aclk);
        encoder_rev <= r;
        encoder_pos <= p;
    endtask : move
    task automatic set_valid(input logic v);
        @(posedge aclk);
        encoder_valid <= v;
    endtask : set_valid
    // Marker kept high four cycles so the synchroniser cannot miss it
    task automatic marker_pulse();
        @(posedge aclk);
        marker_in <= 1'b1;
        repeat (4) @(posedge aclk);
        marker_in <= 1'b0;
    endtask : marker_pulse
    // The freeze comes from this other module; one high cycle is a whole event
    task automatic freeze_pulse();
        @(posedge aclk);
        freeze_in <= 1'b1;
        @(posedge aclk);
        freeze_in <= 1'b0;
    endtask : freeze_pulse
endmodule : feedback_partner
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench of the position capture block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import position_capture_pkg::*;
    // Short counts keep ticks and fan hold inside a brief run
    localparam int unsigned tick_sim = 20;
    localparam int unsigned hold_sim = 50;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic [7:0] board_temp = 8'h19;
    logic [3:0] wstrb = 4'hf;
    logic [3:0] mods = 4'h1;
    logic bready = 1'b0;
    logic rready = 1'b0;
    int cyc = 0;
    logic awready, wready, bvalid, arready, rvalid, fan, trip, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] enc_rev, enc_pos;
    logic enc_valid, marker, freeze;
    int bad_count = 0;
    int check_count = 0;

    always #12.5 aclk = ~aclk;
    // Free cycle count, read right after an edge so two stamps share one phase
    always @(posedge aclk) cyc <= cyc + 1;

    encoder_position_capture #(.fan_hold_count(hold_sim), .tick_count(tick_sim)) u_encoder_position_capture (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .encoder_rev(enc_rev), .encoder_pos(enc_pos), .encoder_valid(enc_valid),
        .marker_in(marker), .freeze_in(freeze), .board_temp(board_temp), .simple_module_count(mods),
        .fan_full_speed(fan), .slot_module_error_trip(trip), .irq(irq));

    feedback_partner u_feedback_partner (.aclk(aclk), .encoder_rev(enc_rev), .encoder_pos(enc_pos),
        .encoder_valid(enc_valid), .marker_in(marker), .freeze_in(freeze));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // A spent wait bound ends the run at once
    task automatic bound(input int n);
        if (n >= 100)
        begin
            bad_count++;
            $display("Error at %0t: wait got %h expected %h", $time, n, 0);
            tally_and_finish();
        end
    endtask : bound
    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask : idle
    // Address and data offered together; each dropped on its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic aw_open, w_open;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_open = 1'b1;
        w_open = 1'b1;
        n = 0;
        while ((aw_open || w_open) && n < 100)
        begin
            @(posedge aclk);
            n++;
            if (aw_open && awready === 1'b1) awvalid <= 1'b0;
            if (w_open && wready === 1'b1) wvalid <= 1'b0;
            aw_open = aw_open && awready !== 1'b1;
            w_open = w_open && wready !== 1'b1;
        end
        while (bvalid !== 1'b1 && n < 100)
        begin
            @(posedge aclk);
            n++;
        end
        bound(n);
        check({30'h0, bresp}, {30'h0, resp_okay});
        // One edge passes so a following call never re-raises bready in the same step
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] eresp);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end while (arready !== 1'b1 && n < 100);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1 && n < 100)
        begin
            @(posedge aclk);
            n++;
        end
        bound(n);
        check(rdata, exp);
        check({30'h0, rresp}, {30'h0, eresp});
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    // Reset state, an unmapped word and a write to a read-only word
    task automatic t_reset_values();
        rd(addr_fault, 32'h0, resp_okay);
        rd(addr_freeze_flag, 32'h0, resp_okay);
        rd(addr_feedback_ready, 32'h0, resp_okay);
        rd(8'h3c, 32'h0, resp_slverr);
        wr(addr_live_rev, 32'h5555);
        rd(addr_live_rev, 32'h0, resp_okay);
    endtask : t_reset_values
    // Ready flag must survive feedback going invalid again
    task automatic t_feedback();
        u_feedback_partner.set_valid(1'b1);
        idle(8);
        rd(addr_feedback_ready, 32'h1, resp_okay);
        u_feedback_partner.set_valid(1'b0);
        idle(8);
        rd(addr_feedback_ready, 32'h1, resp_okay);
    endtask : t_feedback
    task automatic t_live_hold();
        u_feedback_partner.move(16'h1234, 16'h5678);
        idle(8);
        rd(addr_live_rev, 32'h1234, resp_okay);
        rd(addr_live_pos, 32'h5678, resp_okay);
        wr(addr_hold, 32'h1);
        u_feedback_partner.move(16'hffff, 16'habcd);
        idle(8);
        rd(addr_live_rev, 32'h1234, resp_okay);
        wr(addr_hold, 32'h0);
        idle(8);
        rd(addr_live_pos, 32'habcd, resp_okay);
        // A write without its low byte strobe must leave the hold bit alone
        wstrb <= 4'h0;
        wr(addr_hold, 32'h1);
        wstrb <= 4'hf;
        rd(addr_hold, 32'h0, resp_okay);
    endtask : t_live_hold
    // Marker capture at the top count, with its interrupt raised and cleared
    task automatic t_marker();
        wr(addr_irq_mask, 32'h1);
        u_feedback_partner.marker_pulse();
        idle(8);
        rd(addr_marker_rev, 32'hffff, resp_okay);
        rd(addr_marker_pos, 32'habcd, resp_okay);
        rd(addr_live_rev, 32'hffff, resp_okay);
        rd(addr_irq_status, 32'h1, resp_okay);
        check({31'h0, irq}, 32'h1);
        wr(addr_irq_status, 32'h1);
        idle(3);
        check({31'h0, irq}, 32'h0);
    endtask : t_marker
    // Second freeze ignored until software clears the flag
    task automatic t_freeze();
        u_feedback_partner.move(16'h0102, 16'h0304);
        idle(8);
        u_feedback_partner.freeze_pulse();
        idle(48);
        rd(addr_freeze_rev, 32'h0102, resp_okay);
        rd(addr_freeze_pos, 32'h0304, resp_okay);
        rd(addr_freeze_flag, 32'h1, resp_okay);
        u_feedback_partner.move(16'h0506, 16'h0708);
        idle(8);
        u_feedback_partner.freeze_pulse();
        idle(48);
        rd(addr_freeze_rev, 32'h0102, resp_okay);
        wr(addr_freeze_flag, 32'h0);
        u_feedback_partner.freeze_pulse();
        idle(48);
        rd(addr_freeze_pos, 32'h0708, resp_okay);
    endtask : t_freeze
    // Tick period follows the module count: two freeze captures one tick apart are timed on irq
    task automatic t_tick();
        int t1;
        int n;
        mods <= 4'h3;
        wr(addr_irq_mask, 32'h2);
        wr(addr_freeze_flag, 32'h0);
        wr(addr_irq_status, 32'h7);
        u_feedback_partner.freeze_pulse();
        n = 0;
        while (irq !== 1'b1 && n < 100)
        begin
            @(posedge aclk);
            n++;
        end
        bound(n);
        t1 = cyc;
        wr(addr_irq_status, 32'h2);
        wr(addr_freeze_flag, 32'h0);
        u_feedback_partner.freeze_pulse();
        n = 0;
        while (irq !== 1'b1 && n < 100)
        begin
            @(posedge aclk);
            n++;
        end
        bound(n);
        check(cyc - t1, 3 * tick_sim);
        rd(addr_freeze_rev, 32'h0506, resp_okay);
        rd(addr_irq_status, 32'h2, resp_okay);
        mods <= 4'h1;
    endtask : t_tick
    // Fan hold after cooling, then trip and its clearing by drive reset
    task automatic t_thermal();
        board_temp <= 8'h5f;
        idle(6);
        check({31'h0, fan}, 32'h1);
        board_temp <= 8'h50;
        idle(40);
        check({31'h0, fan}, 32'h1);
        idle(20);
        check({31'h0, fan}, 32'h0);
        board_temp <= 8'h65;
        idle(6);
        check({31'h0, trip}, 32'h1);
        rd(addr_fault, {24'h0, fault_overtemp}, resp_okay);
        rd(addr_irq_status, 32'h6, resp_okay);
        board_temp <= 8'h14;
        idle(2);
        wr(addr_drive_reset, 32'h1);
        idle(3);
        rd(addr_fault, 32'h0, resp_okay);
        check({31'h0, trip}, 32'h0);
    endtask : t_thermal

    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        idle(4);
        t_reset_values();
        t_feedback();
        t_live_hold();
        t_marker();
        t_freeze();
        t_tick();
        t_thermal();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire

//--- src/encoder_position_capture.sv
// Position capture, freeze, fault and fan logic of the encoder feedback module, with AXI4-Lite registers
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// R1 - Live revolution and position copies mirror the main values and are untouched by marker or freeze.
// R2 - Each marker activation stores the live revolution and position into the marker registers.
// R3 - There is no freeze pin of its own; the freeze event comes from another option module.
// R4 - Freeze events are evaluated once per update tick of 4 ms times the number of simple modules.
// R5 - A freeze seen with the flag clear stores the position into the freeze registers and sets the flag.
// R6 - Software clears the freeze flag before another freeze may be stored; meanwhile freezes are ignored.
// R7 - The feedback ready flag reads 0 after power-up, becomes 1 on valid feedback and then stays 1.
// R8 - While the hold bit is one the main revolution and position stay unchanged, else they update.
// R9 - A detected error writes its code into the fault register and may raise the slot trip request.
// R10 - The fault register holds zero with no error and a nonzero code up to 255 after an error.
// R11 - A drive reset clears the fault register to zero.
// R12 - Above 90 C the fan is forced to full speed and held so for at least 10 s.
// R13 - Once below 90 C again the forced fan demand is released.
// R14 - Above 100 C the drive is tripped and fault code 74 is loaded.
// R15 - Revolution counts are 16-bit values wrapping 65535 to 0, positions are 16-bit revolution fractions.
module encoder_position_capture
    import position_capture_pkg::*;
#(
    parameter int unsigned fan_hold_count = fan_hold_cycles,
    parameter int unsigned tick_count = tick_cycles
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] encoder_rev,
    input wire logic [15:0] encoder_pos,
    input wire logic encoder_valid,
    input wire logic marker_in,
    input wire logic freeze_in,
    input wire logic [7:0] board_temp,
    input wire logic [3:0] simple_module_count,
    output logic fan_full_speed,
    output logic slot_module_error_trip,
    output logic irq
);
    localparam logic [31:0] tick_last = 32'(tick_count - 1);
    localparam logic [31:0] fan_last = 32'(fan_hold_count - 1);

    // Pin synchronisers; first stage is read only by the second
    logic [2:0] sync1_reg, sync2_reg;
    logic marker_d_reg;
    logic freeze_pend_reg;
    position_s main_reg, marker_reg, freeze_reg;
    logic [15:0] rev_s1_reg, rev_s2_reg, pos_s1_reg, pos_s2_reg;
    logic [7:0] temp_s1_reg, temp_s2_reg;
    logic freeze_flag_reg, feedback_ready_reg, hold_reg;
    logic [7:0] fault_reg;
    logic [irq_width-1:0] irq_status_reg, irq_mask_reg;
    logic [31:0] tick_cnt_reg;
    logic [3:0] tick_mod_reg;
    logic [31:0] fan_cnt_reg;

    always_ff @(posedge aclk)
    begin
        sync1_reg <= {encoder_valid, marker_in, freeze_in};
        sync2_reg <= sync1_reg;
        rev_s1_reg <= encoder_rev;
        rev_s2_reg <= rev_s1_reg;
        pos_s1_reg <= encoder_pos;
        pos_s2_reg <= pos_s1_reg;
        temp_s1_reg <= board_temp;
        temp_s2_reg <= temp_s1_reg;
    end

    wire valid_sync = sync2_reg[2];
    wire marker_sync = sync2_reg[1];
    wire freeze_sync = sync2_reg[0];
    wire marker_rise = marker_sync && !marker_d_reg;

    // Update tick: base period times the fitted simple modules (at least one)
    wire [3:0] tick_mods = (simple_module_count == 4'h0) ? 4'h1 : simple_module_count;
    wire tick_base = (tick_cnt_reg == tick_last);
    wire tick = tick_base && (tick_mod_reg + 4'h1 >= tick_mods); // R4

    // AXI4-Lite write channel: address and data accepted in either order
    logic aw_have_reg, w_have_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    wire wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
    wire wr_lane0 = wr_go && w_strb_reg[0];
    wire wr_flag_clr = wr_lane0 && (aw_addr_reg == addr_freeze_flag) && !w_data_reg[0];
    wire wr_hold = wr_lane0 && (aw_addr_reg == addr_hold);
    wire wr_mask = wr_lane0 && (aw_addr_reg == addr_irq_mask);
    wire wr_irq_clr = wr_lane0 && (aw_addr_reg == addr_irq_status);
    wire drive_reset = wr_lane0 && (aw_addr_reg == addr_drive_reset) && w_data_reg[0];
    wire wr_known = (aw_addr_reg <= addr_drive_reset) && (aw_addr_reg[1:0] == 2'b00);

    // Fault, fan and freeze events
    wire over_trip = temp_s2_reg > temp_trip_c; // R14
    wire over_fan = temp_s2_reg > temp_fan_c; // R12
    wire freeze_take = tick && freeze_pend_reg && !freeze_flag_reg; // R5
    wire [irq_width-1:0] irq_events = {over_trip && (fault_reg != fault_overtemp), freeze_take, marker_rise};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= resp_okay;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                s_axi_wready <= 1'b0;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? resp_okay : resp_slverr;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Read decode
    function automatic logic [31:0] read_word(input logic [7:0] a);
        case (a)
            addr_live_rev: read_word = {16'h0, main_reg.rev}; // R1
            addr_live_pos: read_word = {16'h0, main_reg.pos}; // R1
            addr_marker_rev: read_word = {16'h0, marker_reg.rev};
            addr_marker_pos: read_word = {16'h0, marker_reg.pos};
            addr_freeze_rev: read_word = {16'h0, freeze_reg.rev};
            addr_freeze_pos: read_word = {16'h0, freeze_reg.pos};
            addr_freeze_flag: read_word = {31'h0, freeze_flag_reg};
            addr_feedback_ready: read_word = {31'h0, feedback_ready_reg};
            addr_hold: read_word = {31'h0, hold_reg};
            addr_fault: read_word = {24'h0, fault_reg};
            addr_irq_status: read_word = {29'h0, irq_status_reg};
            addr_irq_mask: read_word = {29'h0, irq_mask_reg};
            default: read_word = 32'h0;
        endcase
    endfunction : read_word
    wire rd_known = (s_axi_araddr <= addr_drive_reset) && (s_axi_araddr[1:0] == 2'b00);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= resp_okay;
            s_axi_arready <= 1'b1;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_word(s_axi_araddr);
            s_axi_rresp <= rd_known ? resp_okay : resp_slverr;
            s_axi_arready <= 1'b0;
        end
        else if (s_axi_rready)
        begin
            // Ready flops track the inverse of the held flags so no bus output is combinational
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Tick divider
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tick_cnt_reg <= 32'h0;
            tick_mod_reg <= 4'h0;
        end
        else if (tick_base)
        begin
            tick_cnt_reg <= 32'h0;
            tick_mod_reg <= tick ? 4'h0 : tick_mod_reg + 4'h1;
        end
        else
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end

    // Position tracking, marker and freeze capture; freeze comes in from the other module's line
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            main_reg <= '0;
            marker_reg <= '0;
            freeze_reg <= '0;
            marker_d_reg <= 1'b0;
            freeze_pend_reg <= 1'b0;
            freeze_flag_reg <= 1'b0;
            hold_reg <= 1'b0;
        end
        else
        begin
            marker_d_reg <= marker_sync;
            if (!hold_reg)
                main_reg <= '{rev: rev_s2_reg, pos: pos_s2_reg}; // R8 R15
            if (marker_rise)
                marker_reg <= main_reg; // R2
            if (freeze_take)
                freeze_reg <= main_reg; // R5
            // A freeze latched between ticks waits for the next tick
            if (freeze_sync) // R3
                freeze_pend_reg <= 1'b1;
            else if (tick)
                freeze_pend_reg <= 1'b0;
            // Capture sets the flag; set wins over a clear in the same cycle
            if (freeze_take)
                freeze_flag_reg <= 1'b1; // R5 R6
            else if (wr_flag_clr)
                freeze_flag_reg <= 1'b0;
            if (wr_hold)
                hold_reg <= w_data_reg[0];
        end
    end

    // Feedback ready is sticky until power is lost, so drive resets do not touch it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            feedback_ready_reg <= 1'b0;
        else if (valid_sync)
            feedback_ready_reg <= 1'b1; // R7
    end

    // Fault code, trip and fan hold
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fault_reg <= fault_none;
            slot_module_error_trip <= 1'b0;
            fan_cnt_reg <= 32'h0;
            fan_full_speed <= 1'b0;
        end
        else
        begin
            if (over_trip)
            begin
                fault_reg <= fault_overtemp; // R14 R9 R10
                slot_module_error_trip <= 1'b1; // R9
            end
            else if (drive_reset)
            begin
                fault_reg <= fault_none; // R11
                slot_module_error_trip <= 1'b0;
            end
            if (over_fan)
                fan_cnt_reg <= fan_last; // R12
            else if (fan_cnt_reg != 32'h0)
                fan_cnt_reg <= fan_cnt_reg - 32'h1;
            fan_full_speed <= over_fan || (fan_cnt_reg != 32'h0); // R12 R13
        end
    end

    // Interrupts: sticky status, write one to clear, events win
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_status_reg <= '0;
            irq_mask_reg <= '0;
            irq <= 1'b0;
        end
        else
        begin
            irq_status_reg <= (irq_status_reg & ~(wr_irq_clr ? w_data_reg[irq_width-1:0] : '0)) | irq_events;
            if (wr_mask)
                irq_mask_reg <= w_data_reg[irq_width-1:0];
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    property p_marker_capture;
        @(posedge aclk) disable iff (!aresetn) marker_rise |=> (marker_reg == $past(main_reg));
    endproperty
    a_marker_capture: assert property (p_marker_capture) else $error("marker capture missed"); // R2

    property p_freeze_guard;
        @(posedge aclk) disable iff (!aresetn) (freeze_flag_reg && !wr_flag_clr) |=> $stable(freeze_reg);
    endproperty
    a_freeze_guard: assert property (p_freeze_guard) else $error("freeze overwritten while flagged"); // R6

    property p_freeze_sets_flag;
        @(posedge aclk) disable iff (!aresetn) freeze_take |=> freeze_flag_reg && freeze_reg == $past(main_reg);
    endproperty
    a_freeze_sets_flag: assert property (p_freeze_sets_flag) else $error("freeze capture wrong"); // R5

    property p_freeze_on_tick;
        @(posedge aclk) disable iff (!aresetn) !tick |=> $stable(freeze_reg);
    endproperty
    a_freeze_on_tick: assert property (p_freeze_on_tick) else $error("freeze outside tick"); // R4

    property p_ready_sticky;
        @(posedge aclk) disable iff (!aresetn) feedback_ready_reg |=> feedback_ready_reg;
    endproperty
    a_ready_sticky: assert property (p_ready_sticky) else $error("ready flag dropped"); // R7

    property p_hold;
        @(posedge aclk) disable iff (!aresetn) hold_reg |=> $stable(main_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("position moved under hold"); // R8

    property p_overtemp;
        @(posedge aclk) disable iff (!aresetn) over_trip |=> fault_reg == fault_overtemp && slot_module_error_trip;
    endproperty
    a_overtemp: assert property (p_overtemp) else $error("overtemp trip missing"); // R14

    property p_fault_clear;
        @(posedge aclk) disable iff (!aresetn) (drive_reset && !over_trip) |=> fault_reg == fault_none;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared"); // R11

    property p_fan;
        @(posedge aclk) disable iff (!aresetn) over_fan |=> ##1 fan_full_speed;
    endproperty
    a_fan: assert property (p_fan) else $error("fan not forced"); // R12
endmodule : encoder_position_capture

`default_nettype wire
